// ---- pkg/pdrt_pkg.sv ----
package pdrt_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int EXT_W = 18;
  localparam int HYS_W = 10;
  localparam int DLY_W = 16;
  localparam int UNIT_W = 10;
  localparam int FLASH_W = 4;

  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [VAL_W-1:0] THR_MIN = 16'shFC19;
  localparam logic signed [VAL_W-1:0] THR_MAX = 16'sh270F;
  localparam logic [HYS_W-1:0] HYS_MAX = 10'h3E7;
  localparam logic signed [VAL_W-1:0] RST_VALUE = 16'sh0000;
  localparam logic signed [VAL_W-1:0] RST_EXTREME = 16'sh7FFF;
  localparam logic [DLY_W-1:0] RST_COUNT = 16'h0000;

  // ----------------------------------------------------------------
  // timing counts, in periods of tick_in
  // ----------------------------------------------------------------
  localparam logic [UNIT_W-1:0] UNIT_TENTH_TICKS = 10'h001;
  localparam logic [UNIT_W-1:0] UNIT_SEC_TICKS = 10'h00A;
  localparam logic [UNIT_W-1:0] UNIT_MIN_TICKS = 10'h258;
  localparam logic [FLASH_W-1:0] FLASH_TICKS = 4'h5;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RELAY_UNUSED = 3'h0,
    MODE_DIRECT = 3'h1,
    MODE_INVERSE = 3'h2,
    MODE_INSIDE = 3'h3,
    MODE_OUTSIDE = 3'h4
  } pdrt_mode_e;

  typedef enum logic [1:0] {
    ALARM_HOLD = 2'h0,
    ALARM_ON = 2'h1,
    ALARM_OFF = 2'h2
  } pdrt_alarm_e;

  typedef enum logic [1:0] {
    UNIT_TENTH = 2'h0,
    UNIT_SEC = 2'h1,
    UNIT_MIN = 2'h2
  } pdrt_unit_e;

  typedef enum logic {
    STYLE_HOLD = 1'b0,
    STYLE_REAL = 1'b1
  } pdrt_style_e;

  typedef enum logic {
    DIR_FALL = 1'b0,
    DIR_RISE = 1'b1
  } pdrt_dir_e;

  typedef enum logic [1:0] {
    DISP_LIVE = 2'h0,
    DISP_TIMED = 2'h1,
    DISP_LATCH = 2'h3
  } pdrt_disp_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic over_range;
    logic signed [VAL_W-1:0] value;
  } pdrt_sample_s;

  typedef struct packed {
    logic signed [VAL_W-1:0] first_threshold;
    logic signed [VAL_W-1:0] second_threshold;
    logic [HYS_W-1:0] hysteresis_half;
    pdrt_mode_e mode;
    logic [DLY_W-1:0] on_delay;
    logic [DLY_W-1:0] off_delay;
    pdrt_unit_e time_unit;
    pdrt_alarm_e alarm_behaviour;
    logic use_peak;
    logic relay_present;
  } pdrt_chan_cfg_s;

endpackage

// ---- core/pdrt_zone.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdrt_zone
  import pdrt_pkg::*;
(
  input wire logic signed [VAL_W-1:0] value_in,
  input wire logic signed [VAL_W-1:0] first_in,
  input wire logic signed [VAL_W-1:0] second_in,
  input wire logic [HYS_W-1:0] hys_in,
  input wire logic dual_in,
  output logic in_a_out,
  output logic in_b_out
);

  logic signed [VAL_W-1:0] t1;
  logic signed [VAL_W-1:0] t2;
  logic signed [EXT_W-1:0] v;
  logic signed [EXT_W-1:0] lo;
  logic signed [EXT_W-1:0] hi;
  logic signed [EXT_W-1:0] h;

  // clamp settings into their legal span before use
  always_comb begin
    t1 = first_in;
    t2 = second_in;
    if (first_in < THR_MIN) t1 = THR_MIN;
    if (first_in > THR_MAX) t1 = THR_MAX;
    if (second_in < THR_MIN) t2 = THR_MIN;
    if (second_in > THR_MAX) t2 = THR_MAX;
    h = (hys_in > HYS_MAX) ? EXT_W'(HYS_MAX) : EXT_W'(hys_in);
  end

  // order thresholds; single mode only looks at lo = first threshold
  always_comb begin
    v = EXT_W'(value_in);
    lo = EXT_W'(t1);
    hi = EXT_W'(t2);
    if (dual_in && (t2 < t1)) begin
      lo = EXT_W'(t2);
      hi = EXT_W'(t1);
    end
  end

  // inside the hysteresis band neither zone is reported
  always_comb begin
    if (dual_in) begin
      in_a_out = (v > lo + h) && (v < hi - h);
      in_b_out = (v > hi + h) || (v < lo - h);
    end else begin
      in_a_out = v > lo + h;
      in_b_out = v < lo - h;
    end
  end

endmodule

`default_nettype wire

// ---- core/pdrt_qual.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdrt_qual
  import pdrt_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic arm_in,
  input wire logic tick_in,
  input wire logic [UNIT_W-1:0] unit_ticks_in,
  input wire logic [DLY_W-1:0] delay_in,
  output logic done_out
);

  logic [UNIT_W-1:0] pre_ff;
  logic [UNIT_W-1:0] nxt_pre;
  logic [DLY_W-1:0] cnt_ff;
  logic [DLY_W-1:0] nxt_cnt;

  // dropping the arm restarts both counters from zero
  always_comb begin
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff;
    if (!arm_in) begin
      nxt_pre = '0;
      nxt_cnt = RST_COUNT;
    end else if (tick_in && (cnt_ff < delay_in)) begin
      if (pre_ff + 1'b1 >= unit_ticks_in) begin
        nxt_pre = '0;
        nxt_cnt = cnt_ff + 1'b1;
      end else begin
        nxt_pre = pre_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pre_ff <= '0;
      cnt_ff <= RST_COUNT;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
    end
  end

  // a zero delay qualifies at once; the tick phase adds up to one tick
  assign done_out = arm_in && (cnt_ff >= delay_in);

endmodule

`default_nettype wire

// ---- core/pdrt_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdrt_top
  import pdrt_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire pdrt_sample_s sample_in,
  input wire logic tick_in,
  input wire logic esc_in,
  input wire logic [VAL_W-1:0] peak_sensitivity_in,
  input wire pdrt_style_e peak_display_style_in,
  input wire logic [DLY_W-1:0] hold_time_in,
  input wire pdrt_chan_cfg_s chan_cfg_in [NUM_CH],
  output logic signed [VAL_W-1:0] display_value_out,
  output logic display_over_range_out,
  output logic showing_peak_out,
  output logic dp_flash_out,
  output logic peak_event_out,
  output logic [NUM_CH-1:0] relay_out,
  output logic [NUM_CH-1:0] led_out
);

  // ----------------------------------------------------------------
  // sample capture and peak tracking
  // ----------------------------------------------------------------
  logic signed [VAL_W-1:0] cur_ff;
  logic signed [VAL_W-1:0] nxt_cur;
  logic over_ff;
  logic nxt_over;
  logic seen_ff;
  logic nxt_seen;
  pdrt_dir_e dir_ff;
  pdrt_dir_e nxt_dir;
  logic signed [VAL_W-1:0] ext_ff;
  logic signed [VAL_W-1:0] nxt_ext;
  logic peak_hit;
  logic signed [VAL_W-1:0] peak_val;
  logic signed [EXT_W-1:0] rise_amt;
  logic signed [EXT_W-1:0] fall_amt;
  logic signed [EXT_W-1:0] sens;

  assign rise_amt = EXT_W'(sample_in.value) - EXT_W'(ext_ff);
  assign fall_amt = EXT_W'(ext_ff) - EXT_W'(sample_in.value);
  assign sens = $signed({2'b00, peak_sensitivity_in});

  // track a minimum while falling, a maximum while rising;
  // out-of-range samples never feed the tracker, they are not real data
  always_comb begin
    nxt_cur = cur_ff;
    nxt_over = over_ff;
    nxt_seen = seen_ff;
    nxt_dir = dir_ff;
    nxt_ext = ext_ff;
    peak_hit = 1'b0;
    peak_val = ext_ff;
    if (sample_in.valid) begin
      nxt_cur = sample_in.value;
      nxt_over = sample_in.over_range;
      nxt_seen = 1'b1;
      if (!sample_in.over_range) begin
        case (dir_ff)
          DIR_FALL: begin
            if (sample_in.value < ext_ff) begin
              nxt_ext = sample_in.value;
            end else if (rise_amt >= sens) begin
              nxt_dir = DIR_RISE;
              nxt_ext = sample_in.value;
            end
          end
          DIR_RISE: begin
            if (sample_in.value > ext_ff) begin
              nxt_ext = sample_in.value;
            end else if (fall_amt >= sens) begin
              peak_hit = 1'b1;
              nxt_dir = DIR_FALL;
              nxt_ext = sample_in.value;
            end
          end
          default: begin
            nxt_dir = DIR_FALL;
            nxt_ext = RST_EXTREME;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= RST_VALUE;
      over_ff <= 1'b0;
      seen_ff <= 1'b0;
      dir_ff <= DIR_FALL;
      ext_ff <= RST_EXTREME;
    end else begin
      cur_ff <= nxt_cur;
      over_ff <= nxt_over;
      seen_ff <= nxt_seen;
      dir_ff <= nxt_dir;
      ext_ff <= nxt_ext;
    end
  end

  // ----------------------------------------------------------------
  // peak presentation and decimal point flashing
  // ----------------------------------------------------------------
  pdrt_disp_e disp_ff;
  pdrt_disp_e nxt_disp;
  logic signed [VAL_W-1:0] held_ff;
  logic signed [VAL_W-1:0] nxt_held;
  logic [DLY_W-1:0] hold_cnt_ff;
  logic [DLY_W-1:0] nxt_hold_cnt;
  logic [FLASH_W-1:0] flash_cnt_ff;
  logic [FLASH_W-1:0] nxt_flash_cnt;
  logic dp_ff;
  logic nxt_dp;
  logic signed [VAL_W-1:0] disp_val_ff;
  logic signed [VAL_W-1:0] nxt_disp_val;
  logic disp_over_ff;
  logic nxt_disp_over;
  logic showing_ff;
  logic nxt_showing;
  logic peak_ev_ff;

  // a fresh peak always wins over timer expiry or escape in the same cycle
  always_comb begin
    nxt_disp = disp_ff;
    nxt_held = held_ff;
    nxt_hold_cnt = hold_cnt_ff;
    if (peak_hit) begin
      nxt_held = peak_val;
      nxt_hold_cnt = RST_COUNT;
      if (hold_time_in != RST_COUNT) begin
        nxt_disp = DISP_TIMED;
      end else if (peak_display_style_in == STYLE_HOLD) begin
        nxt_disp = DISP_LATCH;
      end else begin
        nxt_disp = DISP_LIVE;
      end
    end else begin
      case (disp_ff)
        DISP_LIVE: begin
          nxt_hold_cnt = RST_COUNT;
        end
        DISP_TIMED: begin
          if (hold_time_in == RST_COUNT) begin
            nxt_disp = DISP_LIVE;
          end else if (tick_in) begin
            if (hold_cnt_ff + 1'b1 >= hold_time_in) begin
              nxt_disp = DISP_LIVE;
            end else begin
              nxt_hold_cnt = hold_cnt_ff + 1'b1;
            end
          end
        end
        DISP_LATCH: begin
          if (esc_in) begin
            nxt_disp = DISP_LIVE;
          end
        end
        default: begin
          nxt_disp = DISP_LIVE;
        end
      endcase
    end
  end

  // flash rate is tied to the tick, so it shifts if the tick is retuned
  always_comb begin
    nxt_flash_cnt = flash_cnt_ff;
    nxt_dp = dp_ff;
    if (nxt_disp == DISP_LIVE) begin
      nxt_flash_cnt = '0;
      nxt_dp = 1'b0;
    end else if (tick_in) begin
      if (flash_cnt_ff + 1'b1 >= FLASH_TICKS) begin
        nxt_flash_cnt = '0;
        nxt_dp = !dp_ff;
      end else begin
        nxt_flash_cnt = flash_cnt_ff + 1'b1;
      end
    end
  end

  // shown value: held peak while presenting, otherwise the live sample
  always_comb begin
    nxt_showing = (nxt_disp != DISP_LIVE);
    if (nxt_showing) begin
      nxt_disp_val = nxt_held;
      nxt_disp_over = 1'b0;
    end else begin
      nxt_disp_val = nxt_cur;
      nxt_disp_over = nxt_over;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      disp_ff <= DISP_LIVE;
      held_ff <= RST_VALUE;
      hold_cnt_ff <= RST_COUNT;
      flash_cnt_ff <= '0;
      dp_ff <= 1'b0;
      disp_val_ff <= RST_VALUE;
      disp_over_ff <= 1'b0;
      showing_ff <= 1'b0;
      peak_ev_ff <= 1'b0;
    end else begin
      disp_ff <= nxt_disp;
      held_ff <= nxt_held;
      hold_cnt_ff <= nxt_hold_cnt;
      flash_cnt_ff <= nxt_flash_cnt;
      dp_ff <= nxt_dp;
      disp_val_ff <= nxt_disp_val;
      disp_over_ff <= nxt_disp_over;
      showing_ff <= nxt_showing;
      peak_ev_ff <= peak_hit;
    end
  end

  assign display_value_out = disp_val_ff;
  assign display_over_range_out = disp_over_ff;
  assign showing_peak_out = showing_ff;
  assign dp_flash_out = dp_ff;
  assign peak_event_out = peak_ev_ff;

  // ----------------------------------------------------------------
  // relay channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic signed [VAL_W-1:0] src;
    logic dual;
    logic direct_sense;
    logic in_a;
    logic in_b;
    logic want_on;
    logic want_off;
    logic arm_on;
    logic arm_off;
    logic on_done;
    logic off_done;
    logic [UNIT_W-1:0] unit_ticks;
    logic rel_ff;
    logic nxt_rel;
    logic relay_ff;
    logic led_ff;

    // peak source only differs from live while a peak is presented
    assign src = (chan_cfg_in[i].use_peak && (disp_ff != DISP_LIVE)) ?
                 held_ff : cur_ff;
    assign dual = (chan_cfg_in[i].mode == MODE_INSIDE) ||
                  (chan_cfg_in[i].mode == MODE_OUTSIDE);
    assign direct_sense = (chan_cfg_in[i].mode == MODE_DIRECT) ||
                          (chan_cfg_in[i].mode == MODE_INSIDE);

    pdrt_zone u_zone (
      .value_in(src),
      .first_in(chan_cfg_in[i].first_threshold),
      .second_in(chan_cfg_in[i].second_threshold),
      .hys_in(chan_cfg_in[i].hysteresis_half),
      .dual_in(dual),
      .in_a_out(in_a),
      .in_b_out(in_b)
    );

    // zone A energises in direct/inside, zone B in inverse/outside
    assign want_on = direct_sense ? in_a : in_b;
    assign want_off = direct_sense ? in_b : in_a;
    assign arm_on = seen_ff && !over_ff && !rel_ff && want_on;
    assign arm_off = seen_ff && !over_ff && rel_ff && want_off;

    // one time unit serves both delays, on_delay and off_delay
    always_comb begin
      case (chan_cfg_in[i].time_unit)
        UNIT_TENTH: unit_ticks = UNIT_TENTH_TICKS;
        UNIT_SEC: unit_ticks = UNIT_SEC_TICKS;
        UNIT_MIN: unit_ticks = UNIT_MIN_TICKS;
        default: unit_ticks = UNIT_TENTH_TICKS;
      endcase
    end

    pdrt_qual u_on (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .arm_in(arm_on),
      .tick_in(tick_in),
      .unit_ticks_in(unit_ticks),
      .delay_in(chan_cfg_in[i].on_delay),
      .done_out(on_done)
    );

    pdrt_qual u_off (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .arm_in(arm_off),
      .tick_in(tick_in),
      .unit_ticks_in(unit_ticks),
      .delay_in(chan_cfg_in[i].off_delay),
      .done_out(off_done)
    );

    // unused wins over alarm; undefined mode codes behave as unused
    always_comb begin
      nxt_rel = rel_ff;
      case (chan_cfg_in[i].mode)
        MODE_DIRECT, MODE_INVERSE, MODE_INSIDE, MODE_OUTSIDE: begin
          if (over_ff) begin
            case (chan_cfg_in[i].alarm_behaviour)
              ALARM_ON: nxt_rel = 1'b1;
              ALARM_OFF: nxt_rel = 1'b0;
              default: nxt_rel = rel_ff;
            endcase
          end else if (on_done) begin
            nxt_rel = 1'b1;
          end else if (off_done) begin
            nxt_rel = 1'b0;
          end
        end
        default: begin
          nxt_rel = 1'b0;
        end
      endcase
    end

    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        rel_ff <= 1'b0;
        relay_ff <= 1'b0;
        led_ff <= 1'b0;
      end else begin
        rel_ff <= nxt_rel;
        relay_ff <= nxt_rel && chan_cfg_in[i].relay_present;
        led_ff <= nxt_rel;
      end
    end

    assign relay_out[i] = relay_ff;
    assign led_out[i] = led_ff;
  end

endmodule

`default_nettype wire

// ---- sim/pdrt_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdrt_top_checker
  import pdrt_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire pdrt_sample_s sample_in,
  input wire pdrt_style_e peak_display_style_in,
  input wire logic [DLY_W-1:0] hold_time_in,
  input wire pdrt_chan_cfg_s chan_cfg_in [NUM_CH],
  input wire logic signed [VAL_W-1:0] display_value_out,
  input wire logic showing_peak_out,
  input wire logic dp_flash_out,
  input wire logic peak_event_out,
  input wire logic [NUM_CH-1:0] relay_out,
  input wire logic [NUM_CH-1:0] led_out
);
  // ----------------------------------------------------------------
  // helpers for channel 0
  // ----------------------------------------------------------------
  pdrt_chan_cfg_s c0;
  logic signed [EXT_W-1:0] v0, hi0, lo0;
  logic zd0, al0;
  // borders in the wide type, so threshold minus hysteresis cannot wrap
  assign c0 = chan_cfg_in[0];
  assign v0 = EXT_W'(sample_in.value);
  assign hi0 = EXT_W'(c0.first_threshold) + EXT_W'($signed({1'b0, c0.hysteresis_half}));
  assign lo0 = EXT_W'(c0.first_threshold) - EXT_W'($signed({1'b0, c0.hysteresis_half}));
  assign zd0 = sample_in.valid && !sample_in.over_range && c0.mode == MODE_DIRECT &&
    c0.on_delay == 16'h0000 && c0.off_delay == 16'h0000 && !c0.use_peak && c0.relay_present;
  assign al0 = sample_in.valid && sample_in.over_range && c0.relay_present &&
    c0.mode inside {MODE_DIRECT, MODE_INVERSE, MODE_INSIDE, MODE_OUTSIDE};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_zone_a_on: assert property (zd0 && v0 > hi0 |-> ##2 relay_out[0] && led_out[0])
    else $error("relay not energised two cycles after upper border crossed");
  a_zone_b_off: assert property (zd0 && v0 < lo0 |-> ##2 !relay_out[0] && !led_out[0])
    else $error("relay not released two cycles after lower border crossed");
  a_alarm_forced_on: assert property (
    al0 && c0.alarm_behaviour == ALARM_ON |-> ##2 relay_out[0])
    else $error("alarm did not force relay on");
  a_alarm_forced_off: assert property (
    al0 && c0.alarm_behaviour == ALARM_OFF |-> ##2 !relay_out[0])
    else $error("alarm did not force relay off");
  a_unused_off: assert property (
    (c0.mode == MODE_RELAY_UNUSED) [*3] |-> !relay_out[0] && !led_out[0])
    else $error("unused relay is energised");
  a_absent_relay: assert property (!$past(chan_cfg_in[1].relay_present) |-> !relay_out[1])
    else $error("absent relay is driven");
  a_led_mirror: assert property (
    c0.relay_present && $past(c0.relay_present) |-> led_out[0] == relay_out[0])
    else $error("led differs from its relay");
  a_live_display: assert property (
    sample_in.valid && !sample_in.over_range && peak_display_style_in == STYLE_REAL &&
    hold_time_in == 16'h0000 |=> display_value_out == $past(sample_in.value) && !showing_peak_out)
    else $error("real style with zero hold did not show the live value");
  a_peak_cause: assert property (
    peak_event_out |-> $past(sample_in.valid) && !$past(sample_in.over_range))
    else $error("peak reported without a good sample before it");
  a_flash_idle: assert property (!showing_peak_out [*2] |-> !dp_flash_out)
    else $error("decimal point flashes with no peak shown");

  c_peak: cover property (peak_event_out);
  c_relay_on: cover property ($rose(relay_out[0]));
  c_peak_end: cover property ($fell(showing_peak_out));
endmodule

`default_nettype wire

// ---- sim/pdrt_relay_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

// counts coil changes on relay 0, so chatter inside the band shows up
module pdrt_relay_bank
  import pdrt_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic clk_in,
  input wire logic [NUM_CH-1:0] relay_in,
  output int switches_out
);
  logic prev = 1'b0;
  int n = 0;
  always @(posedge clk_in) begin
    if (relay_in[0] != prev) n++;
    prev = relay_in[0];
  end
  assign switches_out = n;
endmodule

`default_nettype wire

// ---- sim/peak_detect_relay_threshold_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module peak_detect_relay_threshold_ctrl_test;
  import pdrt_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  pdrt_sample_s smp = '0;
  logic tick = 1'b0;
  logic esc = 1'b0;
  logic f0;
  logic [VAL_W-1:0] sens = 16'hFFFF;
  pdrt_style_e style = STYLE_REAL;
  logic [DLY_W-1:0] hold = 16'h0000;
  pdrt_chan_cfg_s cfg [2];
  logic signed [VAL_W-1:0] disp;
  logic disp_or, showing, flash, pk_ev;
  logic [1:0] relay, led;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_peaks = 0;
  int switches, n0, pk;
  int st [2] = '{0, 0};
  bit pk_on = 0;
  logic [31:0] seed = 32'h03146463;

  always #2.5 clk_in = ~clk_in;

  pdrt_top #(.NUM_CH(2)) uut (.clk_in(clk_in), .reset_in(reset_in), .sample_in(smp),
    .tick_in(tick), .esc_in(esc), .peak_sensitivity_in(sens), .peak_display_style_in(style),
    .hold_time_in(hold), .chan_cfg_in(cfg), .display_value_out(disp),
    .display_over_range_out(disp_or), .showing_peak_out(showing), .dp_flash_out(flash),
    .peak_event_out(pk_ev), .relay_out(relay), .led_out(led));
  pdrt_relay_bank #(.NUM_CH(2)) bank (.clk_in(clk_in), .relay_in(relay), .switches_out(switches));

  // ----------------------------------------------------------------
  // model, drivers and checks
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (pk_ev === 1'b1) n_peaks++;
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // 1 for zone a, 2 for zone b, 0 inside a hysteresis band
  function automatic int zone(input int i, input int v);
    int t1, t2, h, lo, hi;
    t1 = cfg[i].first_threshold;
    t2 = cfg[i].second_threshold;
    h = cfg[i].hysteresis_half;
    t1 = (t1 > THR_MAX) ? THR_MAX : ((t1 < THR_MIN) ? THR_MIN : t1);
    t2 = (t2 > THR_MAX) ? THR_MAX : ((t2 < THR_MIN) ? THR_MIN : t2);
    h = (h > HYS_MAX) ? HYS_MAX : h;
    if (cfg[i].mode inside {MODE_DIRECT, MODE_INVERSE}) begin
      if (v > t1 + h) return 1;
      return (v < t1 - h) ? 2 : 0;
    end
    lo = (t1 < t2) ? t1 : t2;
    hi = (t1 < t2) ? t2 : t1;
    if (v > lo + h && v < hi - h) return 1;
    return (v > hi + h || v < lo - h) ? 2 : 0;
  endfunction

  task automatic model(input int v, input bit ovr);
    int z;
    for (int i = 0; i < 2; i++) begin
      z = zone(i, (pk_on && cfg[i].use_peak) ? pk : v);
      if (cfg[i].mode == MODE_RELAY_UNUSED) st[i] = 0;
      else if (ovr) begin
        if (cfg[i].alarm_behaviour == ALARM_ON) st[i] = 1;
        if (cfg[i].alarm_behaviour == ALARM_OFF) st[i] = 0;
      end else if (z == 1) st[i] = cfg[i].mode inside {MODE_DIRECT, MODE_INSIDE};
      else if (z == 2) st[i] = cfg[i].mode inside {MODE_INVERSE, MODE_OUTSIDE};
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  task automatic outs(input int v, input bit ovr);
    if (!ovr) chk(32'(disp), 32'(pk_on ? pk : v));
    chk(32'(disp_or), 32'(ovr));
    chk(32'(showing), 32'(pk_on));
    for (int i = 0; i < 2; i++) begin
      chk(32'(led[i]), 32'(st[i]));
      chk(32'(relay[i]), 32'(st[i] & cfg[i].relay_present));
    end
  endtask

  // one-cycle strobe; the relay path needs two cycles, three more as margin
  task automatic put(input int v, input bit ovr);
    smp = '{valid: 1'b1, over_range: ovr, value: 16'(v)};
    cyc(1);
    smp.valid = 1'b0;
    cyc(4);
  endtask

  task automatic send(input int v, input bit ovr);
    put(v, ovr);
    model(v, ovr);
    outs(v, ovr);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(3);
    end
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cfg[0] = '{first_threshold: 16'sh0064, second_threshold: 16'sh0000,
      hysteresis_half: 10'h00A, mode: MODE_DIRECT, on_delay: 16'h0000, off_delay: 16'h0000,
      time_unit: UNIT_TENTH, alarm_behaviour: ALARM_HOLD, use_peak: 1'b0, relay_present: 1'b1};
    cfg[1] = cfg[0];
    cfg[1].first_threshold = 16'sh00C8;
    cfg[1].second_threshold = 16'sh0032;
    cfg[1].hysteresis_half = 10'h005;
    cfg[1].mode = MODE_INSIDE;
    cfg[1].relay_present = 1'b0;
    cyc(16);
    reset_in = 1'b0;
    // every mode on channel 0; a clear zone value first so a re-evaluation cannot matter
    for (int m = 0; m < 5; m++) begin
      cfg[0].mode = pdrt_mode_e'(m);
      cfg[0].alarm_behaviour = pdrt_alarm_e'(m % 3);
      cfg[1].alarm_behaviour = pdrt_alarm_e'((m + 1) % 3);
      send(300, 0);
      repeat (16) begin
        seed = xs(seed);
        send(int'(seed % 361) - 30, seed[31:29] == 3'h0);
      end
    end
    cfg[0].mode = MODE_DIRECT;
    cfg[0].alarm_behaviour = ALARM_HOLD;
    send(300, 0);
    n0 = switches;
    send(95, 0);
    send(105, 0);
    send(92, 0);
    chk(32'(switches), 32'(n0));
    send(89, 0);
    // on after three ticks in zone a, off after four in zone b
    cfg[0].on_delay = 16'h0003;
    cfg[0].off_delay = 16'h0004;
    put(200, 0);
    ticks(1);
    chk(32'(relay[0]), 32'h0);
    ticks(4);
    chk(32'(relay[0]), 32'h1);
    put(0, 0);
    ticks(3);
    put(200, 0);
    ticks(3);
    put(0, 0);
    ticks(3);
    chk(32'(relay[0]), 32'h1);
    ticks(3);
    chk(32'(relay[0]), 32'h0);
    cfg[0].on_delay = 16'h0000;
    cfg[0].off_delay = 16'h0000;
    send(300, 0);
    // peaks, timed presentation, restart, latch and real style
    sens = 16'h0014;
    hold = 16'h0003;
    style = STYLE_HOLD;
    cfg[0].use_peak = 1'b1;
    send(-500, 0);
    send(50, 0);
    send(100, 0);
    pk = 100;
    pk_on = 1;
    send(70, 0);
    chk(32'(n_peaks), 32'h1);
    ticks(2);
    chk(32'(showing), 32'h1);
    ticks(1);
    pk_on = 0;
    model(70, 0);
    outs(70, 0);
    send(130, 0);
    pk = 130;
    pk_on = 1;
    send(100, 0);
    ticks(2);
    send(160, 0);
    pk = 160;
    send(120, 0);
    ticks(2);
    chk(32'(disp), 32'(pk));
    ticks(1);
    pk_on = 0;
    model(120, 0);
    outs(120, 0);
    hold = 16'h0000;
    send(200, 0);
    pk = 200;
    pk_on = 1;
    send(150, 0);
    f0 = flash;
    ticks(5);
    chk(32'(showing), 32'h1);
    chk(32'(flash), 32'(!f0));
    esc = 1'b1;
    cyc(1);
    esc = 1'b0;
    cyc(3);
    pk_on = 0;
    model(150, 0);
    outs(150, 0);
    chk(32'(flash), 32'h0);
    style = STYLE_REAL;
    send(250, 0);
    send(200, 0);
    chk(32'(n_peaks), 32'h5);
    // out-of-span settings must clamp: unclamped, 11000 would fall in zone b
    cfg[0].first_threshold = 16'sh7000;
    cfg[0].hysteresis_half = 10'h3FF;
    send(8000, 0);
    send(11000, 0);
    results();
  end
endmodule

bind pdrt_top pdrt_top_checker #(.NUM_CH(NUM_CH)) chk_i (.clk_in(clk_in), .reset_in(reset_in),
  .sample_in(sample_in), .peak_display_style_in(peak_display_style_in),
  .hold_time_in(hold_time_in), .chan_cfg_in(chan_cfg_in), .display_value_out(display_value_out),
  .showing_peak_out(showing_peak_out), .dp_flash_out(dp_flash_out),
  .peak_event_out(peak_event_out), .relay_out(relay_out), .led_out(led_out));

`default_nettype wire
